/* File: tsc_defines.svh */
// Constants for the treatment state controller.
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH
`define TSC_KEY_OFF 2'h0
`define TSC_KEY_PREP 2'h1
`define TSC_KEY_TREAT 2'h2
`define TSC_OP_RUNNING 2'h1
`define TSC_OP_ERROR 2'h2
`define TSC_FN_OFF 5'h01
`define TSC_FN_STANDBY 5'h02
`define TSC_FN_PREP 5'h04
`define TSC_FN_READY 5'h08
`define TSC_FN_BEAM_ON 5'h10
`define TSC_CNT_W 32
`define TSC_CNT_RST 32'h0
`endif

/* File: tsc_pkg.sv */
// Types for the treatment state controller.
package tsc_pkg;
  typedef enum logic [1:0] {
    TSC_OP_RUN = 2'h1,
    TSC_OP_ERR = 2'h2
  } tsc_op_state_t;
  typedef enum logic [4:0] {
    TSC_FN_OFF = 5'h01,
    TSC_FN_STBY = 5'h02,
    TSC_FN_PREP = 5'h04,
    TSC_FN_RDY = 5'h08,
    TSC_FN_BEAM = 5'h10
  } tsc_fn_state_t;
endpackage : tsc_pkg

/* File: tsc_sync.sv */
// Two flip-flop synchroniser for one pin input.
`timescale 1ns/1ps
module tsc_sync (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Data
  input wire logic d_i,
  output logic q_o
);
  logic meta_r;
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta_r <= 1'b0;
      q_o <= 1'b0;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule : tsc_sync

/* File: tsc_fault.sv */
// Fault combiner that decides whether the operational machine must enter Error.
`timescale 1ns/1ps
`include "tsc_defines.svh"
module tsc_fault (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Conditions
  input wire logic beam_on_i,
  input wire logic [`TSC_CNT_W-1:0] dose_count_i,
  input wire logic [`TSC_CNT_W-1:0] dose_max_i,
  input wire logic max_valid_i,
  input wire logic estop_i,
  input wire logic wdog_i,
  input wire logic pcnt_fail_i,
  input wire logic cable_disc_i,
  input wire logic coax_variant_i,
  input wire logic fiber_err_i,
  input wire logic hb_en_i,
  input wire logic hb_ok_i,
  input wire logic spot_en_i,
  input wire logic spot_err_i,
  // Result
  output logic fault_o
);
  logic fault_nxt;
  always_comb
  begin
    fault_nxt = 1'b0;
    if (dose_count_i > dose_max_i)
      fault_nxt = 1'b1;
    if (estop_i || wdog_i)
      fault_nxt = 1'b1;
    if (beam_on_i && (pcnt_fail_i || !max_valid_i || fiber_err_i))
      fault_nxt = 1'b1;
    if (beam_on_i && coax_variant_i && cable_disc_i)
      fault_nxt = 1'b1;
    if (beam_on_i && hb_en_i && !hb_ok_i)
      fault_nxt = 1'b1;
    if (spot_en_i && spot_err_i)
      fault_nxt = 1'b1;
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      fault_o <= 1'b0;
    else
      fault_o <= fault_nxt;
  end
endmodule : tsc_fault

/* File: tsc_ctrl.sv */
// Top of the treatment state controller with both state machines.
//
// Behaviour
// - Two independent machines, operational and functional, govern treatment.
// - Both current states are reported to the host and display.
// - Operational machine stays Running only while no fault exists.
// - Error when dose count exceeds configured maximum, any state.
// - Error when emergency stop is latched.
// - Error when processor watchdog times out.
// - In Beam On, pulse counter failure forces Error.
// - In Beam On, invalid maximum threshold forces Error.
// - In Beam On, coaxial variant cable disconnect forces Error.
// - In Beam On, fiber link error forces Error.
// - With checking enabled, missing host heartbeat in Beam On forces Error.
// - With spot option active, spot sequence error forces Error.
// - Functional machine is Off whenever keyswitch is off.
// - Prepare position without authorization gives Standby.
// - Prepare position with authorization gives Preparatory.
// - Treat position with all permissions and no start gives Ready.
// - Treat, start latched, pause clear, permissions held gives Beam On.
// - Overflow relay closed normally, opened when gated counts exceed setting.
// - Pause relay open normally, closed after pause press in Beam On and during Beam On reached via Preparatory.
`timescale 1ns/1ps
`include "tsc_defines.svh"
module tsc_ctrl (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Panel pins
  input wire logic [1:0] keysw_i,
  input wire logic start_btn_i,
  input wire logic pause_btn_i,
  input wire logic estop_i,
  input wire logic cable_disc_i,
  // Host permissions
  input wire logic hb_ok_i,
  input wire logic permit_grant_i,
  input wire logic auth_i,
  input wire logic load_i,
  input wire logic [`TSC_CNT_W-1:0] load_max_i,
  input wire logic [`TSC_CNT_W-1:0] load_sess_i,
  // Configuration and fault sources
  input wire logic [`TSC_CNT_W-1:0] overflow_set_i,
  input wire logic [`TSC_CNT_W-1:0] gated_count_i,
  input wire logic [`TSC_CNT_W-1:0] dose_count_i,
  input wire logic max_valid_i,
  input wire logic wdog_i,
  input wire logic pcnt_fail_i,
  input wire logic coax_variant_i,
  input wire logic fiber_err_i,
  input wire logic hb_en_i,
  input wire logic spot_en_i,
  input wire logic spot_err_i,
  input wire logic err_clear_i,
  // State report
  output logic [1:0] op_state_o,
  output logic [4:0] fn_state_o,
  output logic permit_o,
  output logic loaded_o,
  output logic [`TSC_CNT_W-1:0] max_count_o,
  output logic [`TSC_CNT_W-1:0] session_id_o,
  // Relays
  output logic overflow_relay_closed_o,
  output logic pause_relay_closed_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] key_m_r;
  logic [1:0] key_r;
  logic start_s;
  logic pause_s;
  logic estop_s;
  logic cable_s;
  logic fault;
  logic start_lat_r;
  logic pause_lat_r;
  logic from_prep_r;
  logic perms;
  tsc_pkg::tsc_op_state_t op_r;
  tsc_pkg::tsc_fn_state_t fn_r;
  tsc_pkg::tsc_fn_state_t fn_nxt;

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      key_m_r <= `TSC_KEY_OFF;
      key_r <= `TSC_KEY_OFF;
    end
    else
    begin
      key_m_r <= keysw_i;
      key_r <= key_m_r;
    end
  end

  tsc_sync u_sync_start (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .d_i(start_btn_i),
    .q_o(start_s));
  tsc_sync u_sync_pause (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .d_i(pause_btn_i),
    .q_o(pause_s));
  tsc_sync u_sync_estop (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .d_i(estop_i),
    .q_o(estop_s));
  tsc_sync u_sync_cable (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .d_i(cable_disc_i),
    .q_o(cable_s));

  ////////////////////////////////////////////////////////////////////////////
  tsc_fault u_fault (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .beam_on_i(fn_r == tsc_pkg::TSC_FN_BEAM),
    .dose_count_i(dose_count_i),
    .dose_max_i(max_count_o),
    .max_valid_i(max_valid_i),
    .estop_i(estop_s),
    .wdog_i(wdog_i),
    .pcnt_fail_i(pcnt_fail_i),
    .cable_disc_i(cable_s),
    .coax_variant_i(coax_variant_i),
    .fiber_err_i(fiber_err_i),
    .hb_en_i(hb_en_i),
    .hb_ok_i(hb_ok_i),
    .spot_en_i(spot_en_i),
    .spot_err_i(spot_err_i),
    .fault_o(fault)
  );

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      op_r <= tsc_pkg::TSC_OP_RUN;
    else
      case (op_r)
        tsc_pkg::TSC_OP_RUN:
          if (fault)
            op_r <= tsc_pkg::TSC_OP_ERR;
        tsc_pkg::TSC_OP_ERR:
          if (!fault && err_clear_i)
            op_r <= tsc_pkg::TSC_OP_RUN;
        default:
          op_r <= tsc_pkg::TSC_OP_ERR;
      endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Permit and loads.
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      permit_o <= 1'b0;
      loaded_o <= 1'b0;
      max_count_o <= `TSC_CNT_RST;
      session_id_o <= `TSC_CNT_RST;
    end
    else if (op_r == tsc_pkg::TSC_OP_ERR || fault)
    begin
      permit_o <= 1'b0;
      loaded_o <= 1'b0;
      max_count_o <= `TSC_CNT_RST;
      session_id_o <= `TSC_CNT_RST;
    end
    else
    begin
      permit_o <= permit_grant_i;
      if (load_i)
      begin
        loaded_o <= 1'b1;
        max_count_o <= load_max_i;
        session_id_o <= load_sess_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      start_lat_r <= 1'b0;
      pause_lat_r <= 1'b0;
    end
    else if (key_r != `TSC_KEY_TREAT || op_r == tsc_pkg::TSC_OP_ERR)
    begin
      start_lat_r <= 1'b0;
      pause_lat_r <= 1'b0;
    end
    else
    begin
      if (start_s && fn_r == tsc_pkg::TSC_FN_RDY)
        start_lat_r <= 1'b1;
      if (pause_s && fn_r == tsc_pkg::TSC_FN_BEAM)
        pause_lat_r <= 1'b1;
      else if (start_s)
        pause_lat_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign perms = hb_ok_i && permit_o && auth_i && loaded_o;

  always_comb
  begin
    fn_nxt = tsc_pkg::TSC_FN_OFF;
    case (key_r)
      `TSC_KEY_OFF:
        fn_nxt = tsc_pkg::TSC_FN_OFF;
      `TSC_KEY_PREP:
        fn_nxt = auth_i ? tsc_pkg::TSC_FN_PREP : tsc_pkg::TSC_FN_STBY;
      `TSC_KEY_TREAT:
        if (!perms)
          fn_nxt = auth_i ? tsc_pkg::TSC_FN_PREP : tsc_pkg::TSC_FN_STBY;
        else if (start_lat_r && !pause_lat_r)
          fn_nxt = tsc_pkg::TSC_FN_BEAM;
        else
          fn_nxt = tsc_pkg::TSC_FN_RDY;
      default:
        fn_nxt = tsc_pkg::TSC_FN_OFF;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      fn_r <= tsc_pkg::TSC_FN_OFF;
    else
      fn_r <= fn_nxt;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      from_prep_r <= 1'b0;
    else if (fn_r == tsc_pkg::TSC_FN_PREP)
      from_prep_r <= 1'b1;
    else if (fn_r == tsc_pkg::TSC_FN_BEAM && fn_nxt != tsc_pkg::TSC_FN_BEAM)
      from_prep_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State report.
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      op_state_o <= `TSC_OP_RUNNING;
      fn_state_o <= `TSC_FN_OFF;
    end
    else
    begin
      op_state_o <= op_r;
      fn_state_o <= fn_r;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      overflow_relay_closed_o <= 1'b0;
      pause_relay_closed_o <= 1'b0;
    end
    else if (op_r == tsc_pkg::TSC_OP_ERR || fault)
    begin
      overflow_relay_closed_o <= 1'b0;
      pause_relay_closed_o <= 1'b0;
    end
    else
    begin
      overflow_relay_closed_o <= !(gated_count_i > overflow_set_i);
      if (fn_r == tsc_pkg::TSC_FN_BEAM)
        pause_relay_closed_o <= from_prep_r;
      else
        pause_relay_closed_o <= pause_lat_r && fn_r == tsc_pkg::TSC_FN_RDY && start_lat_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_err_relays;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    op_r == tsc_pkg::TSC_OP_ERR |=> !overflow_relay_closed_o && !pause_relay_closed_o;
  endproperty
  a_err_relays: assert property (p_err_relays) else $error("relay closed in Error");

  property p_fault_err;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    fault |=> op_r == tsc_pkg::TSC_OP_ERR;
  endproperty
  a_fault_err: assert property (p_fault_err) else $error("fault did not enter Error");

  property p_err_loads;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    op_r == tsc_pkg::TSC_OP_ERR |=> !loaded_o && !permit_o;
  endproperty
  a_err_loads: assert property (p_err_loads) else $error("loads kept in Error");

  property p_key_off;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    key_r == `TSC_KEY_OFF |=> fn_r == tsc_pkg::TSC_FN_OFF;
  endproperty
  a_key_off: assert property (p_key_off) else $error("not Off with key off");

  property p_stby;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    key_r == `TSC_KEY_PREP && !auth_i |=> fn_r == tsc_pkg::TSC_FN_STBY;
  endproperty
  a_stby: assert property (p_stby) else $error("not Standby");

  property p_prep;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    key_r == `TSC_KEY_PREP && auth_i |=> fn_r == tsc_pkg::TSC_FN_PREP;
  endproperty
  a_prep: assert property (p_prep) else $error("not Preparatory");

  property p_ready;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    fn_r == tsc_pkg::TSC_FN_RDY |-> $past(key_r) == `TSC_KEY_TREAT && $past(perms);
  endproperty
  a_ready: assert property (p_ready) else $error("Ready without permissions");

  sequence s_beam_cause;
    key_r == `TSC_KEY_TREAT && perms && start_lat_r && !pause_lat_r;
  endsequence
  property p_beam;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    s_beam_cause |=> fn_r == tsc_pkg::TSC_FN_BEAM;
  endproperty
  a_beam: assert property (p_beam) else $error("Beam On not entered");

  property p_report;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    ##1 fn_state_o == $past(fn_r) && op_state_o == $past(op_r);
  endproperty
  a_report: assert property (p_report) else $error("state report lags");

  property p_overflow;
    @(posedge sys_clk_i) disable iff (!rstn_i)
    gated_count_i > overflow_set_i |=> !overflow_relay_closed_o;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow relay closed");

endmodule : tsc_ctrl

/* File: tsc_far_model.sv */
// Far-side model of keyswitch, buttons, emergency stop and host permissions.
`timescale 1ns/1ps
module tsc_far_model (
  // Clock
  input wire logic sys_clk_i,
  // Panel
  output logic [1:0] keysw_o,
  output logic start_btn_o,
  output logic pause_btn_o,
  output logic estop_o,
  output logic cable_disc_o,
  // Host
  output logic hb_ok_o,
  output logic permit_grant_o,
  output logic auth_o,
  output logic load_o,
  output logic [31:0] load_max_o,
  output logic [31:0] load_sess_o
);
  // Lines: 0 estop, 1 cable, 2 heartbeat, 3 permit, 4 authorization.
  logic [4:0] line_r;
  assign estop_o = line_r[0];
  assign cable_disc_o = line_r[1];
  assign hb_ok_o = line_r[2];
  assign permit_grant_o = line_r[3];
  assign auth_o = line_r[4];
  initial
  begin
    keysw_o = 2'h0;
    start_btn_o = 1'b0;
    pause_btn_o = 1'b0;
    load_o = 1'b0;
    load_max_o = 32'h0;
    load_sess_o = 32'h0;
    line_r = 5'h0c;
  end
  task set_key(input logic [1:0] k);
    @(negedge sys_clk_i);
    keysw_o = k;
  endtask : set_key
  task set_line(input int i, input logic v);
    @(negedge sys_clk_i);
    line_r[i] = v;
  endtask : set_line
  // Holds a button long enough for the pin synchroniser.
  task press(input logic is_pause);
    @(negedge sys_clk_i);
    if (is_pause) pause_btn_o = 1'b1;
    else start_btn_o = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    pause_btn_o = 1'b0;
    start_btn_o = 1'b0;
  endtask : press
  // Data is scrambled once the load pulse has gone.
  task load(input logic [31:0] m, input logic [31:0] s);
    @(negedge sys_clk_i);
    load_o = 1'b1;
    load_max_o = m;
    load_sess_o = s;
    @(negedge sys_clk_i);
    load_o = 1'b0;
    load_max_o = ~m;
    load_sess_o = ~s;
  endtask : load
endmodule : tsc_far_model

/* File: tsc_ctrl_bench.sv */
// Self-checking testbench of the treatment state controller.
`timescale 1ns/1ps
module tsc_ctrl_bench;
  logic sys_clk_i, rstn_i, start_b, pause_b, estop, cable, hb_ok, grant, auth, load;
  logic mval, wdog, pfail, coax, fiber, hb_en, spot_en, spot_err, eclr;
  logic permit, loaded, ovf_rel, pau_rel;
  logic [1:0] keysw, op;
  logic [4:0] fn;
  logic [31:0] lmax, lsess, ovf_set, gated, dose, maxc, sess;
  int mismatches, comparisons, i;
  tsc_far_model u_tsc_far_model (.sys_clk_i(sys_clk_i), .keysw_o(keysw),
    .start_btn_o(start_b), .pause_btn_o(pause_b), .estop_o(estop), .cable_disc_o(cable),
    .hb_ok_o(hb_ok), .permit_grant_o(grant), .auth_o(auth), .load_o(load),
    .load_max_o(lmax), .load_sess_o(lsess));
  tsc_ctrl u_tsc_ctrl (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .keysw_i(keysw),
    .start_btn_i(start_b), .pause_btn_i(pause_b), .estop_i(estop), .cable_disc_i(cable),
    .hb_ok_i(hb_ok), .permit_grant_i(grant), .auth_i(auth), .load_i(load),
    .load_max_i(lmax), .load_sess_i(lsess), .overflow_set_i(ovf_set),
    .gated_count_i(gated), .dose_count_i(dose), .max_valid_i(mval), .wdog_i(wdog),
    .pcnt_fail_i(pfail), .coax_variant_i(coax), .fiber_err_i(fiber), .hb_en_i(hb_en),
    .spot_en_i(spot_en), .spot_err_i(spot_err), .err_clear_i(eclr), .op_state_o(op),
    .fn_state_o(fn), .permit_o(permit), .loaded_o(loaded), .max_count_o(maxc),
    .session_id_o(sess), .overflow_relay_closed_o(ovf_rel), .pause_relay_closed_o(pau_rel));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wait_fn(input logic [4:0] e);
    for (int n = 0; n < 16 && fn !== e; n++) @(negedge sys_clk_i);
    chk("fn_state", {27'h0, e}, {27'h0, fn});
  endtask : wait_fn
  task wait_op(input logic [1:0] e);
    for (int n = 0; n < 16 && op !== e; n++) @(negedge sys_clk_i);
    chk("op_state", {30'h0, e}, {30'h0, op});
  endtask : wait_op
  task fault(input int k, input logic v);
    @(negedge sys_clk_i);
    case (k)
      1: u_tsc_far_model.set_line(0, v);
      2: wdog = v;
      3: pfail = v;
      4: mval = ~v;
      5: u_tsc_far_model.set_line(1, v);
      6: fiber = v;
      7: u_tsc_far_model.set_line(2, ~v);
      8: spot_err = v;
      default: dose = v ? 32'h101 : 32'h0;
    endcase
  endtask : fault
  task go_beam();
    u_tsc_far_model.set_key(2'h1);
    u_tsc_far_model.set_line(4, 1'b1);
    wait_fn(tsc_pkg::TSC_FN_PREP);
    u_tsc_far_model.load(32'h100, 32'h5a);
    u_tsc_far_model.set_key(2'h2);
    wait_fn(tsc_pkg::TSC_FN_RDY);
    u_tsc_far_model.press(1'b0);
    wait_fn(tsc_pkg::TSC_FN_BEAM);
  endtask : go_beam
  task chk_err();
    chk("permit", 32'h0, {31'h0, permit});
    chk("loaded", 32'h0, {31'h0, loaded});
    chk("max_count", 32'h0, maxc);
    chk("session", 32'h0, sess);
    chk("ovf_relay", 32'h0, {31'h0, ovf_rel});
    chk("pause_relay", 32'h0, {31'h0, pau_rel});
  endtask : chk_err
  task clear();
    for (int k = 0; k < 9; k++) fault(k, 1'b0);
    eclr = 1'b1;
    repeat (8) @(negedge sys_clk_i);
    eclr = 1'b0;
    wait_op(tsc_pkg::TSC_OP_RUN);
  endtask : clear
  task report_and_stop();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (20000) @(negedge sys_clk_i);
    mismatches++;
    report_and_stop();
  end
  initial
  begin
    mismatches = 0;
    comparisons = 0;
    rstn_i = 1'b0;
    {wdog, pfail, fiber, spot_err, eclr} = 5'h0;
    {mval, coax, hb_en, spot_en} = 4'hf;
    ovf_set = 32'h80;
    gated = 32'h0;
    dose = 32'h0;
    repeat (8) @(negedge sys_clk_i);
    chk("ovf_relay", 32'h0, {31'h0, ovf_rel});
    rstn_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    wait_op(tsc_pkg::TSC_OP_RUN);
    wait_fn(tsc_pkg::TSC_FN_OFF);
    chk("ovf_relay", 32'h1, {31'h0, ovf_rel});
    chk("pause_relay", 32'h0, {31'h0, pau_rel});
    u_tsc_far_model.set_key(2'h1);
    wait_fn(tsc_pkg::TSC_FN_STBY);
    u_tsc_far_model.set_key(2'h0);
    wait_fn(tsc_pkg::TSC_FN_OFF);
    go_beam();
    chk("max_count", 32'h100, maxc);
    chk("session", 32'h5a, sess);
    chk("pause_relay", 32'h1, {31'h0, pau_rel});
    // Overflow relay opens only above the setting.
    gated = 32'h81;
    repeat (6) @(negedge sys_clk_i);
    chk("ovf_relay", 32'h0, {31'h0, ovf_rel});
    gated = 32'h80;
    repeat (6) @(negedge sys_clk_i);
    chk("ovf_relay", 32'h1, {31'h0, ovf_rel});
    // Dose equal to the maximum is still allowed.
    dose = 32'h100;
    repeat (6) @(negedge sys_clk_i);
    chk("op_state", 32'h1, {30'h0, op});
    u_tsc_far_model.press(1'b1);
    repeat (8) @(negedge sys_clk_i);
    u_tsc_far_model.press(1'b0);
    wait_fn(tsc_pkg::TSC_FN_BEAM);
    chk("pause_relay", 32'h0, {31'h0, pau_rel});
    u_tsc_far_model.press(1'b1);
    repeat (4) @(negedge sys_clk_i);
    chk("pause_relay", 32'h1, {31'h0, pau_rel});
    for (i = 0; i < 9; i++)
    begin
      go_beam();
      fault(i, 1'b1);
      wait_op(tsc_pkg::TSC_OP_ERR);
      chk_err();
      clear();
    end
    // Beam-only faults are ignored outside Beam On.
    for (i = 3; i < 7; i++)
    begin
      fault(i, 1'b1);
      repeat (6) @(negedge sys_clk_i);
      chk("op_state", 32'h1, {30'h0, op});
      fault(i, 1'b0);
    end
    // Disabled options mask their faults; overflow follows a new setting.
    {coax, hb_en, spot_en} = 3'h0;
    ovf_set = 32'h200;
    gated = 32'h1ff;
    go_beam();
    for (i = 5; i < 9; i++)
    begin
      if (i != 6)
      begin
        fault(i, 1'b1);
        repeat (6) @(negedge sys_clk_i);
        chk("op_state", 32'h1, {30'h0, op});
        fault(i, 1'b0);
      end
    end
    chk("ovf_relay", 32'h1, {31'h0, ovf_rel});
    gated = 32'h201;
    repeat (6) @(negedge sys_clk_i);
    chk("ovf_relay", 32'h0, {31'h0, ovf_rel});
    report_and_stop();
  end
endmodule : tsc_ctrl_bench
